/* shared/epp_pkg.sv */
// constants for the prom byte programmer
// assumes a 125 MHz clock and a prom that follows the pin table
package epp_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ       = 125;
  localparam int PULSE_US      = 200;
  localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
  localparam int OPW_MIN_US    = 190;
  localparam int OPW_MAX_US    = 5250;
  localparam int SETUP_US      = 2;
  localparam int SETUP_CYC     = SETUP_US * CLK_MHZ;
  localparam int ACCESS_NS     = 150;
  localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_OP_PULSES = OPW_MAX_US / PULSE_US;
  // ------------------------------------------------------------
  // address span, retry limit and states
  // ------------------------------------------------------------
  localparam int          ADDR_W     = 17;
  localparam logic [16:0] ADDR_FIRST = 17'h01000;
  localparam logic [16:0] ADDR_LAST  = 17'h1FFFF;
  localparam int          MAX_TRIES  = 25;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SETUP  = 4'h1,
    ST_PULSE  = 4'h2,
    ST_VSET   = 4'h3,
    ST_VERIFY = 4'h4,
    ST_OSET   = 4'h5,
    ST_OVER   = 4'h6,
    ST_NEXT   = 4'h7,
    ST_RSET   = 4'h8,
    ST_READ   = 4'h9,
    ST_DONE   = 4'hA,
    ST_FAIL   = 4'hB
  } epp_state_type;
endpackage

/* testbench/epp_prom_model.sv */
`timescale 1ns/1ps
// behavioural prom that the programmer drives
// assumes the bench resolves the data wire and erases before each run
module epp_prom_model (
  // prom pins
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        pgm_n_i,
  input  wire logic        vpp_high_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             drive_o,
  // faults commanded by the bench
  input  wire logic        stuck_i,
  input  wire logic        corrupt_i
);
  logic [7:0] mem  [0:131071];
  int         hits [0:131071];
  // ------------------------------------------------------------
  // erase and read
  // ------------------------------------------------------------
  task automatic erase();
    for (int i = 0; i < 131072; i++) begin
      mem[i]  = 8'hFF;
      hits[i] = 0;
    end
  endtask
  assign drive_o = !cs_n_i && !oe_n_i;
  assign data_o  = (corrupt_i && !vpp_high_i) ? mem[addr_i] ^ 8'h01
                                              : mem[addr_i];
  // ------------------------------------------------------------
  // programming: a byte sticks after addr[1:0]+1 pulses
  // ------------------------------------------------------------
  always @(posedge pgm_n_i) begin
    if (vpp_high_i && !cs_n_i && oe_n_i) begin
      hits[addr_i] = hits[addr_i] + 1;
      if (!stuck_i && hits[addr_i] > int'(addr_i[1:0]))
        mem[addr_i] = data_i;
    end
  end
endmodule

/* testbench/eprom_mode_byte_programmer_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the prom programmer with a prom model
// assumes short pulse and setup counts and a four-byte area
module eprom_mode_byte_programmer_tb;
  localparam int          PW    = 4;
  localparam int          TRIES = 4;
  localparam logic [16:0] A0    = 17'h01000;
  localparam logic [16:0] A1    = 17'h01003;
  logic        clk_i   = 1'b0;
  logic        nrst_i  = 1'b0;
  logic        ce_i    = 1'b1;
  logic        start_i = 1'b0;
  logic        stuck   = 1'b0;
  logic        corrupt = 1'b0;
  logic        ce_gap  = 1'b0;
  logic        busy, done, fail, mism, vpp, vcc, p_oe, cs_n, oe_n, pgm_n;
  logic [16:0] src_addr, addr;
  logic [7:0]  src, p_data, m_data, bus;
  logic [7:0]  bus_q   = 8'h00;
  logic        m_drive;
  logic [16:0] cur     = 17'h0;
  logic [3:0]  rd_seen = 4'h0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          pw_cnt = 0;
  int          npulse = 0;
  always #4 clk_i = ~clk_i;
  // released wire shows a changing pattern
  assign bus = p_oe ? p_data : (m_drive ? m_data : ~bus_q);
  assign src = src_addr[7:0] ^ 8'hA5;
  always @(posedge clk_i) bus_q <= bus;
  always @(negedge clk_i) if (ce_gap) ce_i <= ~ce_i;
  epp_programmer #(.PULSE_CYCLES(PW), .SETUP_CYCLES(2), .MAX_TRIES(TRIES),
    .ADDR_FIRST(A0), .ADDR_LAST(A1)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .start_i(start_i),
    .busy_o(busy), .done_o(done), .fail_o(fail), .mismatch_o(mism),
    .src_addr_o(src_addr), .src_data_i(src), .vpp_high_o(vpp),
    .vcc_prog_o(vcc), .prom_address_bus_o(addr), .prom_data_bus_i(bus),
    .prom_data_bus_o(p_data), .prom_data_bus_oe_o(p_oe),
    .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
    .program_strobe_n_o(pgm_n));
  epp_prom_model i_prom (
    .cs_n_i(cs_n), .oe_n_i(oe_n), .pgm_n_i(pgm_n), .vpp_high_i(vpp),
    .addr_i(addr), .data_i(bus), .data_o(m_data), .drive_o(m_drive),
    .stuck_i(stuck), .corrupt_i(corrupt));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic pulse_start();
    @(negedge clk_i) start_i = 1'b1;
    repeat (2) @(negedge clk_i);
    start_i = 1'b0;
  endtask
  task automatic run(input bit again);
    cur = '0;
    npulse = 0;
    rd_seen = '0;
    i_prom.erase();
    if (done || fail) pulse_start();
    pulse_start();
    if (again) begin
      repeat (30) @(negedge clk_i);
      check(busy === 1'b1, "busy in run");
      pulse_start();
    end
    for (int i = 0; i < 20000 && !(done || fail); i++) @(negedge clk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // pin monitor
  // ------------------------------------------------------------
  always @(negedge clk_i) begin
    if (nrst_i && !pgm_n) begin
      if (pw_cnt == 0 && addr !== cur) begin
        if (cur != 0) check(npulse == int'(cur[1:0]) + 2, "over pulse");
        check(addr === ((cur == 0) ? A0 : cur + 17'h1), "address order");
        check(addr >= A0 && addr <= A1, "address range");
        cur = addr;
        npulse = 0;
      end
      if (pw_cnt == 0) npulse++;
      check(vpp && vcc && oe_n && !cs_n && p_oe, "program levels");
      check(p_data === src && src_addr === addr, "program byte");
      pw_cnt++;
    end else if (pw_cnt != 0) begin
      check(ce_gap || pw_cnt == ((!stuck && npulse == int'(cur[1:0]) + 2)
            ? PW * npulse - PW : PW), "pulse width");
      check(stuck || npulse <= int'(cur[1:0]) + 2, "pulse count");
      pw_cnt = 0;
    end
    if (m_drive && p_oe) check(1'b0, "bus clash");
    if (busy && !vpp && !vcc && !cs_n && !oe_n) rd_seen[addr[1:0]] = 1'b1;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_program();
    run(1'b1);
    check(done === 1'b1 && fail === 1'b0 && mism === 1'b0, "flags");
    check(busy === 1'b0, "busy after run");
    check(cur === A1 && npulse == 5, "last address");
    check(rd_seen === 4'hF, "final read");
    for (int a = A0; a <= A1; a++)
      check(i_prom.mem[a] === (a[7:0] ^ 8'hA5), "stored byte");
  endtask
  task automatic test_fail();
    stuck = 1'b1;
    ce_gap = 1'b1;
    run(1'b0);
    check(fail === 1'b1 && done === 1'b0, "fail flag");
    check(cur === A0 && npulse == TRIES, "retry bound");
    ce_gap = 1'b0;
    @(negedge clk_i) ce_i = 1'b1;
    stuck = 1'b0;
  endtask
  task automatic test_reset();
    pulse_start();
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b0;
    @(negedge clk_i);
    check(pgm_n === 1'b1 && cs_n === 1'b1, "reset strobes");
    check(oe_n === 1'b1 && p_oe === 1'b0, "reset bus");
    check(vpp === 1'b0 && vcc === 1'b0, "reset supply");
    repeat (7) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(busy === 1'b0 && done === 1'b0, "idle after reset");
  endtask
  task automatic test_mismatch();
    corrupt = 1'b1;
    run(1'b0);
    check(done === 1'b1 && mism === 1'b1 && fail === 1'b0, "mismatch");
    corrupt = 1'b0;
  endtask
  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    test_reset();
    test_program();
    test_fail();
    test_mismatch();
    stop_test();
  end
endmodule

/* verilog/epp_programmer.sv */
`timescale 1ns/1ps
// prom programmer: drives address, data and strobes of the prom
// assumes supply switches are external, steered by the supply outputs
module epp_programmer #(
  parameter int          PULSE_CYCLES = epp_pkg::PULSE_CYC,
  parameter int          SETUP_CYCLES = epp_pkg::SETUP_CYC,
  parameter int          MAX_TRIES    = epp_pkg::MAX_TRIES,
  parameter logic [16:0] ADDR_FIRST   = epp_pkg::ADDR_FIRST,
  parameter logic [16:0] ADDR_LAST    = epp_pkg::ADDR_LAST
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // command
  input  wire logic        start_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             fail_o,
  output logic             mismatch_o,
  // image source: byte for the address on src_addr_o
  output logic [16:0]      src_addr_o,
  input  wire logic [7:0]  src_data_i,
  // supply control
  output logic             vpp_high_o,
  output logic             vcc_prog_o,
  // prom pins
  output logic [16:0]      prom_address_bus_o,
  input  wire logic [7:0]  prom_data_bus_i,
  output logic [7:0]       prom_data_bus_o,
  output logic             prom_data_bus_oe_o,
  output logic             chip_select_n_o,
  output logic             output_enable_n_o,
  output logic             program_strobe_n_o
);
  localparam int TW = 24;
  localparam int NW = 8;

  if (MAX_TRIES < 1 || MAX_TRIES > epp_pkg::MAX_OP_PULSES ||
      MAX_TRIES * PULSE_CYCLES >= (1 << TW) || PULSE_CYCLES < 1 ||
      MAX_TRIES >= (1 << NW) || ADDR_FIRST > ADDR_LAST) begin : g_param_chk
    $error("epp_programmer: parameters out of range");
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    epp_pkg::epp_state_type st;
    logic [16:0]            addr;
    logic [7:0]             data;
    logic [NW-1:0]          pulses;
    logic                   vpp;
    logic                   vcc6;
    logic                   ce_n;
    logic                   oe_n;
    logic                   pgm_n;
    logic                   drive;
    logic                   done;
    logic                   fail;
    logic                   mism;
  } epp_ctl_type;
  epp_ctl_type s_reg;
  epp_ctl_type s_next;

  logic          t_start;
  logic [TW-1:0] t_count;
  logic          t_done;

  epp_timer #(.W(TW)) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .start_i (t_start),
    .count_i (t_count),
    .done_o  (t_done)
  );

  always_comb begin
    s_next  = s_reg;
    t_start = 1'b0;
    t_count = TW'(SETUP_CYCLES);
    unique case (s_reg.st)
      epp_pkg::ST_IDLE: begin
        if (start_i) begin
          s_next.addr   = ADDR_FIRST;
          s_next.vpp    = 1'b1;
          s_next.vcc6   = 1'b1;
          s_next.done   = 1'b0;
          s_next.fail   = 1'b0;
          s_next.mism   = 1'b0;
          s_next.pulses = '0;
          s_next.st     = epp_pkg::ST_SETUP;
          t_start       = 1'b1;
        end
      end
      epp_pkg::ST_SETUP: begin
        // program mode: select low, output enable high, byte driven
        s_next.ce_n  = 1'b0;
        s_next.oe_n  = 1'b1;
        s_next.drive = 1'b1;
        s_next.data  = src_data_i;
        if (t_done) begin
          s_next.pgm_n = 1'b0;
          s_next.st    = epp_pkg::ST_PULSE;
          t_count      = TW'(PULSE_CYCLES);
          t_start      = 1'b1;
        end
      end
      epp_pkg::ST_PULSE: begin
        if (t_done) begin
          s_next.pgm_n  = 1'b1;
          s_next.pulses = s_reg.pulses + NW'(1);
          s_next.st     = epp_pkg::ST_VSET;
          t_start       = 1'b1;
        end
      end
      epp_pkg::ST_VSET: begin
        if (t_done) begin
          s_next.drive = 1'b0;
          s_next.oe_n  = 1'b0;
          s_next.st    = epp_pkg::ST_VERIFY;
          t_count      = TW'(SETUP_CYCLES);
          t_start      = 1'b1;
        end
      end
      epp_pkg::ST_VERIFY: begin
        if (t_done) begin
          s_next.oe_n = 1'b1;
          t_start     = 1'b1;
          if (prom_data_bus_i == s_reg.data) begin
            s_next.st = epp_pkg::ST_OSET;
          end else if (s_reg.pulses >= NW'(MAX_TRIES)) begin
            s_next.st   = epp_pkg::ST_FAIL;
            s_next.fail = 1'b1;
          end else begin
            s_next.st = epp_pkg::ST_SETUP;
          end
        end
      end
      epp_pkg::ST_OSET: begin
        s_next.drive = 1'b1;
        if (t_done) begin
          s_next.pgm_n = 1'b0;
          s_next.st    = epp_pkg::ST_OVER;
          // X pulses times 0.2 ms, X bounded to keep 5.25 ms
          t_count      = TW'(s_reg.pulses) * TW'(PULSE_CYCLES);
          t_start      = 1'b1;
        end
      end
      epp_pkg::ST_OVER: begin
        if (t_done) begin
          s_next.pgm_n  = 1'b1;
          s_next.pulses = '0;
          s_next.st     = epp_pkg::ST_NEXT;
        end
      end
      epp_pkg::ST_NEXT: begin
        t_start = 1'b1;
        if (s_reg.addr == ADDR_LAST) begin
          s_next.vpp  = 1'b0;
          s_next.vcc6 = 1'b0;
          s_next.drive = 1'b0;
          s_next.addr = ADDR_FIRST;
          s_next.ce_n = 1'b1;
          s_next.st   = epp_pkg::ST_RSET;
        end else begin
          s_next.addr = s_reg.addr + 17'h00001;
          s_next.st   = epp_pkg::ST_SETUP;
        end
      end
      epp_pkg::ST_RSET: begin
        s_next.data = src_data_i;
        if (t_done) begin
          s_next.ce_n = 1'b0;
          s_next.oe_n = 1'b0;
          s_next.st   = epp_pkg::ST_READ;
          t_start     = 1'b1;
        end
      end
      epp_pkg::ST_READ: begin
        if (t_done) begin
          if (prom_data_bus_i != s_reg.data) begin
            s_next.mism = 1'b1;
          end
          if (s_reg.addr == ADDR_LAST) begin
            s_next.ce_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.done = 1'b1;
            s_next.st   = epp_pkg::ST_DONE;
          end else begin
            s_next.addr = s_reg.addr + 17'h00001;
            s_next.st   = epp_pkg::ST_RSET;
            t_start     = 1'b1;
          end
        end
      end
      epp_pkg::ST_DONE, epp_pkg::ST_FAIL: begin
        s_next.ce_n  = 1'b1;
        s_next.oe_n  = 1'b1;
        s_next.pgm_n = 1'b1;
        s_next.drive = 1'b0;
        s_next.vpp   = 1'b0;
        s_next.vcc6  = 1'b0;
        if (start_i) begin
          s_next.st = epp_pkg::ST_IDLE;
        end
      end
      default: s_next.st = epp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg       <= '0;
      s_reg.ce_n  <= 1'b1;
      s_reg.oe_n  <= 1'b1;
      s_reg.pgm_n <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign busy_o             = s_reg.st != epp_pkg::ST_IDLE &&
                              s_reg.st != epp_pkg::ST_DONE &&
                              s_reg.st != epp_pkg::ST_FAIL;
  assign done_o             = s_reg.done;
  assign fail_o             = s_reg.fail;
  assign mismatch_o         = s_reg.mism;
  assign src_addr_o         = s_reg.addr;
  assign vpp_high_o         = s_reg.vpp;
  assign vcc_prog_o         = s_reg.vcc6;
  assign prom_address_bus_o = s_reg.addr;
  assign prom_data_bus_o    = s_reg.data;
  assign prom_data_bus_oe_o = s_reg.drive;
  assign chip_select_n_o    = s_reg.ce_n;
  assign output_enable_n_o  = s_reg.oe_n;
  assign program_strobe_n_o = s_reg.pgm_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_strobe_mode: assert property (@(posedge clk_i) disable iff (!rst_n)
    !s_reg.pgm_n |-> !s_reg.ce_n && s_reg.oe_n && s_reg.vpp)
    else $error("strobe low outside programming mode");
  a_drive_float: assert property (@(posedge clk_i) disable iff (!rst_n)
    !s_reg.oe_n |-> !s_reg.drive)
    else $error("bus driven while prom output enabled");
  a_start_first: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && s_reg.st == epp_pkg::ST_IDLE && start_i |=>
      s_reg.addr == ADDR_FIRST && s_reg.vpp)
    else $error("sequence not started at first address");
  a_addr_range: assert property (@(posedge clk_i) disable iff (!rst_n)
    !s_reg.pgm_n |-> s_reg.addr >= ADDR_FIRST && s_reg.addr <= ADDR_LAST)
    else $error("programming outside allowed range");
  a_verify_mode: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_reg.st == epp_pkg::ST_VERIFY |-> !s_reg.oe_n && s_reg.pgm_n)
    else $error("verify with wrong strobes");
  a_retry_bound: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_reg.pulses <= NW'(MAX_TRIES))
    else $error("retry count above limit");
  a_advance_one: assert property (@(posedge clk_i) disable iff (!rst_n)
    ce_i && s_reg.st == epp_pkg::ST_NEXT && s_reg.addr != ADDR_LAST |=>
      s_reg.addr == $past(s_reg.addr) + 17'h00001)
    else $error("address not advanced by one");
  a_final_read: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_reg.st == epp_pkg::ST_READ |-> !s_reg.vpp && !s_reg.vcc6)
    else $error("final read with raised supplies");
  a_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(s_reg.pgm_n) |-> s_reg.drive)
    else $error("byte released with the strobe edge");
  sequence s_pulse_end;
    ce_i && s_reg.st == epp_pkg::ST_PULSE && t_done;
  endsequence
  a_count_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_pulse_end |=> s_reg.pulses == $past(s_reg.pulses) + NW'(1) &&
      s_reg.pgm_n)
    else $error("pulse not counted");
endmodule

/* verilog/epp_timer.sv */
`timescale 1ns/1ps
// down counter for pulse and setup timing
// assumes a synchronous start pulse and the package timing constants
module epp_timer #(
  parameter int W = 24
) (
  // clock, reset and enable
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // control
  input  wire logic         start_i,
  input  wire logic [W-1:0] count_i,
  // status
  output logic              done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } epp_tmr_type;
  epp_tmr_type tmr_reg;
  epp_tmr_type tmr_next;

  if (W < 2) begin : g_w_chk
    $error("epp_timer: width too small");
  end

  always_comb begin
    tmr_next = tmr_reg;
    if (start_i) begin
      tmr_next.cnt  = count_i;
      tmr_next.busy = 1'b1;
    end else if (tmr_reg.busy) begin
      if (tmr_reg.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
        tmr_next.busy = 1'b0;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_reg <= '0;
    end else if (ce_i) begin
      tmr_reg <= tmr_next;
    end
  end

  assign done_o = tmr_reg.busy && (tmr_reg.cnt <= {{(W-1){1'b0}}, 1'b1});
endmodule
